// File: cmb_buffer.sv
// Function
// R1: in standard format the identifier is 11 bits and goes out msb first.
// R2: identifier bits 10..3 sit in ident byte zero and bits 2..0 in bits 7..5 of ident byte one.
// R3: the smallest identifier value has the highest arbitration priority.
// R4: bit 4 of ident byte one is the remote flag, stored on receive and sent on transmit, 0 meaning data frame; extended frames use bit 0 of ident byte three.
// R5: bit 3 of ident byte one is the format flag, recorded on receive and selecting 11 or 29 bits on transmit.
// R6: eight payload byte registers hold the transmitted or received payload in buffer order; the code stores no payload of received extended frames.
// R7: only as many payload bytes as the length code says are sent or received.
// R8: a remote frame carries the programmed length code unchanged and no payload bytes.
// R9: data frame payload counts lie in 0 to 8 and software programs lengths within that range.
// R10: with the format flag set the four ident bytes are read as a 29-bit identifier.
// R11: the length code is a 4-bit binary count equal to the byte count for 0 to 8.
// R12: in standard format ident bytes two and three are ignored when building a frame.
`timescale 1ns/10ps
`include "cmb_params.svh"
module cmb_buffer (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // serial frame stream, one bit per tx_bit_en
  input  wire logic        tx_bit_en,
  output logic             tx_bit,
  output logic             tx_bit_valid,
  output logic             tx_busy,
  // byte-wide receive port from the bit engine
  input  wire logic        rx_hdr_valid,
  input  wire logic [28:0] rx_ident,
  input  wire logic        rx_ext,
  input  wire logic        rx_remote,
  input  wire logic [3:0]  rx_length,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_done
);
  typedef struct packed {
    cmb_pkg::cmb_state_t st;
    logic [3:0][7:0] ident;
    logic [7:0]  length_code;
    logic [5:0]  cnt;
    logic [2:0]  byte_idx;
    logic [3:0]  rx_cnt;
    logic        mode_rx;
    logic        rx_full;
    logic        tx_done;
    logic        dph;
    logic        dph_wr;
    logic [3:0]  dph_idx;
    logic        rd_pend;
    logic [31:0] rdata;
    logic [7:0]  txbyte;
  } cmb_reg_t;

  cmb_reg_t r;
  cmb_reg_t next_r;
  default clocking cmb_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  logic       mem_sw_we;
  logic [2:0] mem_sw_addr;
  logic       mem_hw_we;
  logic [2:0] mem_hw_addr;
  logic [2:0] mem_rd_addr;
  logic [7:0] mem_rd_data;
  logic       addr_phase;
  logic       go_tx;
  logic [3:0] payload_cnt;
  logic [28:0] tx_ident;
  logic       tx_ext;
  logic       tx_remote;
  logic [5:0] id_len;

  assign addr_phase = hsel && htrans[1] && hready;

  // transmit identifier: extended mapping only when the format flag is set
  assign tx_ext    = r.ident[1][`CMB_IDE_BIT];  // see R5
  assign tx_remote = tx_ext ? r.ident[3][0] : r.ident[1][`CMB_RTR_BIT];  // see R4
  always_comb
  begin
    if (tx_ext)  // see R10
      tx_ident = {r.ident[0], r.ident[1][7:5], r.ident[1][2:0], r.ident[2], r.ident[3][7:1]};
    else  // see R2 see R12
      tx_ident = {18'h00000, r.ident[0], r.ident[1][7:5]};
  end
  assign id_len = tx_ext ? 6'(`CMB_EXT_ID_BITS) : 6'(`CMB_STD_ID_BITS);  // see R1

  // payload count from the plain binary length code, clamped at eight
  always_comb
  begin
    if (tx_remote)
      payload_cnt = 4'h0;  // see R8
    else if (r.length_code[3:0] > `CMB_MAX_BYTES)
      payload_cnt = `CMB_MAX_BYTES;  // see R9 see R11
    else
      payload_cnt = r.length_code[3:0];  // see R7
  end

  assign go_tx = r.dph && r.dph_wr && r.dph_idx == `CMB_IDX_CTRL && hwdata[0];

  always_comb
  begin
    next_r = r;
    mem_sw_we   = 1'b0;
    mem_sw_addr = 3'(r.dph_idx - `CMB_IDX_PAYLOAD0);
    mem_hw_we   = 1'b0;
    mem_hw_addr = r.rx_cnt[2:0];
    mem_rd_addr = r.byte_idx;
    next_r.dph = addr_phase;
    next_r.rd_pend = 1'b0;
    if (addr_phase)
    begin
      next_r.dph_wr  = hwrite;
      next_r.dph_idx = haddr[5:2];
    end
    if (r.dph && r.dph_wr)
    begin
      if (r.dph_idx <= `CMB_IDX_IDENT3)
        next_r.ident[r.dph_idx[1:0]] = hwdata[7:0];
      else if (r.dph_idx <= `CMB_IDX_PAYLOAD7)
        mem_sw_we = 1'b1;  // see R6
      else if (r.dph_idx == `CMB_IDX_LENGTH)
        next_r.length_code = {4'h0, hwdata[3:0]};
      else if (r.dph_idx == `CMB_IDX_CTRL)
        next_r.mode_rx = hwdata[1];
      else if (r.dph_idx == `CMB_IDX_STATUS)
      begin
        if (hwdata[0])
          next_r.tx_done = 1'b0;
        if (hwdata[1])
          next_r.rx_full = 1'b0;
      end
    end
    // read: payload reads while idle take one extra cycle through the byte memory
    if (r.dph && !r.dph_wr && r.st == cmb_pkg::CMB_IDLE && !r.rd_pend
        && r.dph_idx >= `CMB_IDX_PAYLOAD0 && r.dph_idx <= `CMB_IDX_PAYLOAD7)
    begin
      mem_rd_addr   = 3'(r.dph_idx - `CMB_IDX_PAYLOAD0);
      next_r.rd_pend = 1'b1;
      next_r.dph     = 1'b1;
    end
    unique case (r.st)
      cmb_pkg::CMB_IDLE:
      begin
        if (go_tx && !r.mode_rx)
        begin
          next_r.st  = cmb_pkg::CMB_ID;
          next_r.cnt = id_len - 6'h01;
          next_r.byte_idx = 3'h0;
        end
      end
      cmb_pkg::CMB_ID:
        if (tx_bit_en)
        begin
          // msb first so a lower value wins a wired-and arbitration
          if (r.cnt == 6'h00)  // see R1 see R3
          begin
            next_r.st  = cmb_pkg::CMB_CTL;
            next_r.cnt = 6'h01;
          end
          else
            next_r.cnt = r.cnt - 6'h01;
        end
      cmb_pkg::CMB_CTL:
        if (tx_bit_en)
        begin
          if (r.cnt == 6'h00)
          begin
            next_r.st  = cmb_pkg::CMB_DLC;
            next_r.cnt = 6'h03;
          end
          else
            next_r.cnt = r.cnt - 6'h01;
        end
      cmb_pkg::CMB_DLC:
        if (tx_bit_en)
        begin
          if (r.cnt == 6'h00)
          begin
            next_r.cnt = 6'h07;
            next_r.txbyte = mem_rd_data;
            next_r.byte_idx = 3'h1;
            next_r.st  = (payload_cnt == 4'h0) ? cmb_pkg::CMB_DONE : cmb_pkg::CMB_DATA;  // see R7 see R8
          end
          else
            next_r.cnt = r.cnt - 6'h01;
        end
      cmb_pkg::CMB_DATA:
        if (tx_bit_en)
        begin
          if (r.cnt == 6'h00)
          begin
            next_r.cnt = 6'h07;
            next_r.txbyte = mem_rd_data;
            next_r.byte_idx = 3'(r.byte_idx + 3'h1);
            if ({1'b0, r.byte_idx} == payload_cnt || r.byte_idx == 3'h0)
              next_r.st = cmb_pkg::CMB_DONE;  // see R7
          end
          else
            next_r.cnt = r.cnt - 6'h01;
        end
      cmb_pkg::CMB_DONE:
      begin
        next_r.tx_done = 1'b1;
        next_r.st = cmb_pkg::CMB_IDLE;
      end
      default:
        next_r.st = cmb_pkg::CMB_IDLE;
    endcase
    // receive path, only in receive mode
    if (r.mode_rx && rx_hdr_valid)
    begin
      next_r.rx_cnt = 4'h0;
      if (rx_ext)  // see R10
      begin
        next_r.ident[0] = rx_ident[28:21];
        next_r.ident[1] = {rx_ident[20:18], 1'b1, 1'b1, rx_ident[17:15]};
        next_r.ident[2] = rx_ident[14:7];
        next_r.ident[3] = {rx_ident[6:0], rx_remote};
      end
      else  // see R2 see R4 see R5
      begin
        next_r.ident[0] = rx_ident[10:3];
        next_r.ident[1] = {rx_ident[2:0], rx_remote, 1'b0, 3'h0};
      end
      next_r.length_code = {4'h0, rx_length};  // see R11
    end
    if (r.mode_rx && rx_byte_valid && r.rx_cnt < r.length_code[3:0]
        && r.rx_cnt < `CMB_MAX_BYTES && !r.ident[1][`CMB_RTR_BIT])  // see R7 see R9
    begin
      mem_hw_we = 1'b1;  // see R6
      next_r.rx_cnt = r.rx_cnt + 4'h1;
    end
    if (r.mode_rx && rx_done)
      next_r.rx_full = 1'b1;
    // captured at the address phase so the word already stands in the data phase
    next_r.rdata = 32'h0;
    if (addr_phase && !hwrite)
    begin
      if (haddr[5:2] <= `CMB_IDX_IDENT3)
        next_r.rdata = {24'h0, next_r.ident[haddr[3:2]]};
      else if (haddr[5:2] <= `CMB_IDX_PAYLOAD7)
        next_r.rdata = {24'h0, mem_rd_data};
      else if (haddr[5:2] == `CMB_IDX_LENGTH)
        next_r.rdata = {24'h0, next_r.length_code};
      else if (haddr[5:2] == `CMB_IDX_CTRL)
        next_r.rdata = {30'h0, next_r.mode_rx, 1'b0};
      else if (haddr[5:2] == `CMB_IDX_STATUS)
        next_r.rdata = {29'h0, next_r.st != cmb_pkg::CMB_IDLE, next_r.rx_full, next_r.tx_done};
      else
        next_r.rdata = {3'h0, tx_ident};
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      r <= '0;
    else
      r <= next_r;
  end

  cmb_bytes #(.DEPTH(8)) u_bytes (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .sw_we    (mem_sw_we),
    .sw_addr  (mem_sw_addr),
    .sw_wdata (hwdata[7:0]),
    .hw_we    (mem_hw_we),
    .hw_addr  (mem_hw_addr),
    .hw_wdata (rx_byte),
    .rd_addr  (mem_rd_addr),
    .rd_data  (mem_rd_data)
  );

  // payload read stalls one cycle while idle; writes, other reads and payload reads during a transmit are zero wait
  assign hreadyout = !(r.dph && !r.dph_wr && !r.rd_pend && r.st == cmb_pkg::CMB_IDLE
                       && r.dph_idx >= `CMB_IDX_PAYLOAD0 && r.dph_idx <= `CMB_IDX_PAYLOAD7);
  assign hresp  = 1'b0;
  assign hrdata = (r.rd_pend) ? {24'h0, mem_rd_data} : r.rdata;

  always_comb
  begin
    tx_bit = 1'b1;
    unique case (r.st)
      cmb_pkg::CMB_ID:   tx_bit = tx_ident[r.cnt[4:0]];  // see R1
      cmb_pkg::CMB_CTL:  tx_bit = (r.cnt == 6'h01) ? tx_remote : tx_ext;
      cmb_pkg::CMB_DLC:  tx_bit = r.length_code[r.cnt[1:0]];  // see R8
      cmb_pkg::CMB_DATA: tx_bit = r.txbyte[r.cnt[2:0]];
      default:           tx_bit = 1'b1;
    endcase
  end
  assign tx_bit_valid = tx_bit_en && r.st != cmb_pkg::CMB_IDLE && r.st != cmb_pkg::CMB_DONE;
  assign tx_busy      = r.st != cmb_pkg::CMB_IDLE;

  property p_remote_no_data;
    @(posedge sys_clk) disable iff (!rstn)
      (r.st == cmb_pkg::CMB_DLC && tx_remote) |-> r.st != cmb_pkg::CMB_DATA ##1 r.st != cmb_pkg::CMB_DATA;
  endproperty
  a_remote_no_data: assert property (p_remote_no_data) else $error("remote frame sent payload");  // see R8
  property p_std_len;
    @(posedge sys_clk) disable iff (!rstn)
      (r.st == cmb_pkg::CMB_IDLE && go_tx && !r.mode_rx && !tx_ext) |=> r.cnt == 6'h0a;
  endproperty
  a_std_len: assert property (p_std_len) else $error("standard identifier not 11 bits");  // see R1
  property p_rx_count;
    @(posedge sys_clk) disable iff (!rstn)
      mem_hw_we |-> r.rx_cnt < r.length_code[3:0];
  endproperty
  a_rx_count: assert property (p_rx_count) else $error("received byte beyond length");  // see R7
  property p_ext_len;
    (r.st == cmb_pkg::CMB_IDLE && go_tx && !r.mode_rx && tx_ext) |=> r.cnt == 6'h1c;
  endproperty
  a_ext_len: assert property (p_ext_len) else $error("extended identifier not 29 bits");  // see R10
  property p_rx_remote;
    (r.mode_rx && rx_hdr_valid && !rx_ext) |=> r.ident[1][`CMB_RTR_BIT] == $past(rx_remote);
  endproperty
  a_rx_remote: assert property (p_rx_remote) else $error("received remote flag not stored");  // see R4
  sequence s_frame_close;
    r.st == cmb_pkg::CMB_DONE ##1 (r.st == cmb_pkg::CMB_IDLE && r.tx_done);
  endsequence
  property p_remote_close;
    (r.st == cmb_pkg::CMB_DLC && r.cnt == 6'h00 && tx_bit_en && tx_remote) |=> s_frame_close;
  endproperty
  a_remote_close: assert property (p_remote_close) else $error("remote frame did not close after length");  // see R8
endmodule : cmb_buffer

// File: cmb_params.svh
`ifndef CMB_PARAMS_SVH
`define CMB_PARAMS_SVH

// register word indices (the byte offset is index * 4)
`define CMB_IDX_IDENT0    4'h0
`define CMB_IDX_IDENT1    4'h1
`define CMB_IDX_IDENT2    4'h2
`define CMB_IDX_IDENT3    4'h3
`define CMB_IDX_PAYLOAD0  4'h4
`define CMB_IDX_PAYLOAD7  4'hb
`define CMB_IDX_LENGTH    4'hc
`define CMB_IDX_CTRL      4'hd
`define CMB_IDX_STATUS    4'he
`define CMB_IDX_RXID      4'hf

// field positions in ident_byte_one
`define CMB_RTR_BIT       4
`define CMB_IDE_BIT       3

`define CMB_MAX_BYTES     4'h8
`define CMB_STD_ID_BITS   11
`define CMB_EXT_ID_BITS   29

`endif

// File: cmb_pkg.sv
package cmb_pkg;
  typedef enum logic [2:0] {
    CMB_IDLE,
    CMB_ID,
    CMB_CTL,
    CMB_DLC,
    CMB_DATA,
    CMB_DONE
  } cmb_state_t;
endpackage : cmb_pkg

// File: cmb_bytes.sv
`timescale 1ns/10ps
// eight payload byte registers, two write ports, registered read
module cmb_bytes #(
  parameter int DEPTH = 8
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rstn,
  input  wire logic                     sw_we,
  input  wire logic [$clog2(DEPTH)-1:0] sw_addr,
  input  wire logic [7:0]               sw_wdata,
  input  wire logic                     hw_we,
  input  wire logic [$clog2(DEPTH)-1:0] hw_addr,
  input  wire logic [7:0]               hw_wdata,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [7:0]               rd_data
);
  logic [7:0] mem [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_byte
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
          mem[g] <= 8'h00;
        // hardware reception wins over a simultaneous software write
        else if (hw_we && hw_addr == g)
          mem[g] <= hw_wdata;
        else if (sw_we && sw_addr == g)
          mem[g] <= sw_wdata;
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rd_data <= 8'h00;
    else
      rd_data <= mem[rd_addr];
  end
endmodule : cmb_bytes

// File: cmb_link_model.sv
`timescale 1ns/10ps
// far-side bit engine: paces transmit bits, records them, plays received frames
module cmb_link_model (
  input  wire logic  sys_clk,
  input  wire logic  rstn,
  input  wire logic  slow,
  input  wire logic  cap_clr,
  input  wire logic  tx_bit,
  input  wire logic  tx_bit_valid,
  input  wire logic  tx_busy,
  output logic       tx_bit_en,
  output logic [127:0] cap,
  output logic [7:0] ncap,
  output logic       rx_hdr_valid,
  output logic [28:0] rx_ident,
  output logic       rx_ext,
  output logic       rx_remote,
  output logic [3:0] rx_length,
  output logic       rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic       rx_done
);
  logic [1:0] pace;

  // slow pacing gives one bit every third cycle, like a real bit timer
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      pace <= 2'h0;
      tx_bit_en <= 1'b0;
    end
    else
    begin
      pace <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
      tx_bit_en <= tx_busy && (!slow || pace == 2'h0);
    end

  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      cap <= '0;
      ncap <= 8'h00;
    end
    else if (cap_clr)
    begin
      cap <= '0;
      ncap <= 8'h00;
    end
    else if (tx_bit_valid)
    begin
      cap <= {cap[126:0], tx_bit};
      ncap <= ncap + 8'h01;
    end

  initial
  begin
    rx_hdr_valid = 1'b0;
    rx_ident = '0;
    rx_ext = 1'b0;
    rx_remote = 1'b0;
    rx_length = 4'h0;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    rx_done = 1'b0;
  end

  // fields go stale after each pulse: identifier, length and byte show the inverse so nothing leans on them
  task automatic rx_frame(input logic [28:0] id, input logic ext, input logic rem, input logic [3:0] len,
                          input logic [63:0] data, input int nb);
    @(posedge sys_clk);
    rx_hdr_valid <= 1'b1;
    rx_ident <= id;
    rx_ext <= ext;
    rx_remote <= rem;
    rx_length <= len;
    @(posedge sys_clk);
    rx_hdr_valid <= 1'b0;
    rx_ident <= ~id;
    rx_length <= ~len;
    for (int i = 0; i < nb; i++)
    begin
      rx_byte_valid <= 1'b1;
      rx_byte <= data[63-8*i -: 8];
      @(posedge sys_clk);
      rx_byte_valid <= 1'b0;
      rx_byte <= ~data[63-8*i -: 8];
      @(posedge sys_clk);
    end
    rx_done <= 1'b1;
    @(posedge sys_clk);
    rx_done <= 1'b0;
  endtask : rx_frame
endmodule : cmb_link_model

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
  logic         sys_clk, rstn, hsel, hwrite, hready, hreadyout, hresp, slow, cap_clr;
  logic         tx_bit_en, tx_bit, tx_bit_valid, tx_busy;
  logic         rx_hdr_valid, rx_ext, rx_remote, rx_byte_valid, rx_done;
  logic [7:0]   haddr, rx_byte, ncap;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [31:0]  hwdata, hrdata, rd;
  logic [28:0]  rx_ident;
  logic [3:0]   rx_length;
  logic [127:0] cap;
  int           n_fail, n_tests;

  assign hready = hreadyout;

  cmb_buffer dut_u (.*);
  cmb_link_model link_u (.*);

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  task automatic chkf(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkf

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk32({31'h0, hresp}, 32'h0);
  endtask : ahb

  function automatic logic [7:0] pb(input int i);
    return 8'(8'h3c + 41 * i);
  endfunction : pb

  task automatic regs_case();
    ahb(1'b0, 8'h00, 32'h0);
    chk32(rd, 32'h0);
    ahb(1'b1, 8'h00, 32'ha5);
    ahb(1'b1, 8'h2c, 32'h5c);
    ahb(1'b0, 8'h2c, 32'h0);
    chk32(rd, 32'h5c);
    ahb(1'b0, 8'h00, 32'h0);
    chk32(rd, 32'ha5);
    ahb(1'b1, 8'h30, 32'h8);
    ahb(1'b0, 8'h30, 32'h0);
    chk32(rd, 32'h8);
    ahb(1'b0, 8'h3c, 32'h0);
    chk32(rd, 32'h528);
  endtask : regs_case

  task automatic tx_case(input logic ext, input logic [28:0] id, input logic rtr, input logic [3:0] len,
                         input logic s);
    logic [127:0] e;
    int           n;
    if (ext)
    begin
      ahb(1'b1, 8'h00, {24'h0, id[28:21]});
      ahb(1'b1, 8'h04, {24'h0, id[20:18], 2'b01, id[17:15]});
      ahb(1'b1, 8'h08, {24'h0, id[14:7]});
      ahb(1'b1, 8'h0c, {24'h0, id[6:0], rtr});
      e = {99'h0, id};
      n = 35;
    end
    else
    begin
      ahb(1'b1, 8'h00, {24'h0, id[10:3]});
      ahb(1'b1, 8'h04, {24'h0, id[2:0], rtr, 4'h0});
      // junk in the upper bytes must not leak into a standard frame
      ahb(1'b1, 8'h08, 32'h5a);
      ahb(1'b1, 8'h0c, 32'hc3);
      e = {117'h0, id[10:0]};
      n = 17;
    end
    e = {e[121:0], rtr, ext, len};
    for (int i = 0; i < 8; i++)
      ahb(1'b1, 8'h10 + 8'(4 * i), {24'h0, pb(i)});
    for (int i = 0; i < 8 && i < len && !rtr; i++)
    begin
      e = {e[119:0], pb(i)};
      n += 8;
    end
    ahb(1'b1, 8'h30, {28'h0, len});
    slow <= s;
    cap_clr <= 1'b1;
    @(posedge sys_clk);
    cap_clr <= 1'b0;
    ahb(1'b1, 8'h34, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk32({31'h0, tx_busy}, 32'h1);
    for (int k = 0; k < 2000 && tx_busy !== 1'b0; k++)
      @(posedge sys_clk);
    chkf(128'(ncap), 128'(n));
    chkf(cap, e);
    ahb(1'b0, 8'h38, 32'h0);
    chk32(rd & 32'h5, 32'h1);
    ahb(1'b1, 8'h38, 32'h1);
    ahb(1'b0, 8'h38, 32'h0);
    chk32(rd & 32'h1, 32'h0);
  endtask : tx_case

  task automatic rx_case();
    ahb(1'b1, 8'h18, 32'hee);
    ahb(1'b1, 8'h34, 32'h2);
    // a third byte arrives beyond the length and must be dropped
    link_u.rx_frame(29'h6d5, 1'b0, 1'b0, 4'h2, 64'h1122330000000000, 3);
    repeat (2) @(posedge sys_clk);
    ahb(1'b0, 8'h00, 32'h0);
    chk32(rd, 32'hda);
    ahb(1'b0, 8'h04, 32'h0);
    chk32(rd & 32'hf8, 32'ha0);
    ahb(1'b0, 8'h30, 32'h0);
    chk32(rd, 32'h2);
    ahb(1'b0, 8'h10, 32'h0);
    chk32(rd, 32'h11);
    ahb(1'b0, 8'h14, 32'h0);
    chk32(rd, 32'h22);
    ahb(1'b0, 8'h18, 32'h0);
    chk32(rd, 32'hee);
    ahb(1'b0, 8'h38, 32'h0);
    chk32(rd & 32'h2, 32'h2);
    // a remote frame brings no payload, so the stored bytes stay
    link_u.rx_frame(29'h6d5, 1'b0, 1'b1, 4'h2, 64'h0, 0);
    repeat (2) @(posedge sys_clk);
    ahb(1'b0, 8'h04, 32'h0);
    chk32(rd & 32'hf8, 32'hb0);
    ahb(1'b0, 8'h30, 32'h0);
    chk32(rd, 32'h2);
    ahb(1'b0, 8'h10, 32'h0);
    chk32(rd, 32'h11);
  endtask : rx_case

  task automatic close_out();
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  initial
  begin
    n_fail = 0;
    n_tests = 0;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    slow = 1'b0;
    cap_clr = 1'b0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    regs_case();
    tx_case(1'b0, 29'h5a3, 1'b0, 4'h3, 1'b0);
    tx_case(1'b0, 29'h0c1, 1'b1, 4'h5, 1'b1);
    tx_case(1'b0, 29'h7ff, 1'b0, 4'h8, 1'b1);
    tx_case(1'b0, 29'h400, 1'b0, 4'h0, 1'b0);
    tx_case(1'b0, 29'h0f0, 1'b0, 4'hb, 1'b0);
    tx_case(1'b1, 29'h0abcdef1, 1'b0, 4'h2, 1'b0);
    rx_case();
    close_out();
  end

  // whole run is under a thousand cycles; this is 50000 cycles, over fifty times that
  initial
  begin
    #200000;
    n_fail++;
    close_out();
  end
endmodule : testbench
